// [rtl/asd_pkg.sv]
// constants for the headset switch detection and protection register bank
package asd_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_EVENT_FLAGS   = 8'h18;
  localparam logic [7:0] OFF_DETECT_MASK   = 8'h19;
  localparam logic [7:0] OFF_ORIENT_A      = 8'h1A;
  localparam logic [7:0] OFF_ORIENT_B      = 8'h1B;
  localparam logic [7:0] OFF_MIC_LOWER     = 8'h1C;
  localparam logic [7:0] OFF_MIC_UPPER     = 8'h1D;
  localparam logic [7:0] OFF_SOFT_RESET    = 8'h1E;
  localparam logic [7:0] OFF_CUR_SELECT    = 8'h1F;
  localparam logic [7:0] OFF_CUR_STATE     = 8'h20;
  localparam logic [7:0] OFF_GATE_CONTROL  = 8'h21;
  localparam logic [7:0] OFF_PROT_ENABLE   = 8'h22;
  localparam logic [7:0] OFF_PROT_STATE    = 8'h23;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [4:0] RST_EVENT_FLAGS   = 5'h00;
  localparam logic [4:0] RST_DETECT_MASK   = 5'h08;
  localparam logic [7:0] RST_ORIENT        = 8'h00;
  localparam logic [7:0] RST_MIC_LOWER     = 8'h20;
  localparam logic [7:0] RST_MIC_UPPER     = 8'hFF;
  localparam logic [1:0] RST_CUR_SELECT    = 2'h2;
  localparam logic [2:0] RST_GATE_CONTROL  = 3'h0;
  localparam logic [1:0] RST_PROT_ENABLE   = 2'h3;
  localparam logic [5:0] RST_PROT_STATE    = 6'h20;

  // ****************************************************************
  // field positions and codes
  // ****************************************************************
  localparam int         BIT_GATE_EN       = 2;
  localparam int         BIT_OVP_EN        = 1;
  localparam int         BIT_OCP_EN        = 0;
  localparam int         BIT_SOFT_RESET    = 0;
  localparam logic [2:0] PATH_TO_GROUND    = 3'h2;
  localparam logic [2:0] BIT_LAST          = 3'h7;

  // bus address of the device, value is arbitrary
  localparam logic [6:0] DEV_ADDR          = 7'h42;

  // ****************************************************************
  // serial interface states
  // ****************************************************************
  typedef enum logic [3:0] {
    SER_IDLE      = 4'b0000,
    SER_ADDR      = 4'b0001,
    SER_ADDR_ACK  = 4'b0010,
    SER_REG       = 4'b0011,
    SER_REG_ACK   = 4'b0100,
    SER_WDATA     = 4'b0101,
    SER_WDATA_ACK = 4'b0110,
    SER_RDATA     = 4'b0111,
    SER_RDATA_ACK = 4'b1000
  } asd_ser_type;

endpackage : asd_pkg

// [rtl/asd_regs.sv]
// two-wire serial slave and detection, threshold and protection register bank
`timescale 1ns/10ps

module asd_regs
  import asd_pkg::*;
(
  input  wire logic       clock_in,                 // 125 MHz system clock
  input  wire logic       sys_rst_in,               // asynchronous reset, active high
  input  wire logic       scl_in,                   // serial clock pin level
  input  wire logic       sda_in,                   // serial data pin level
  output logic            sda_out,                  // serial data drive value, always low
  output logic            sda_oe_n_out,             // low while pulling data line low
  output logic            int_n_out,                // interrupt drive value, always low
  output logic            int_oe_n_out,             // low while interrupt is asserted
  input  wire logic [4:0] event_set_in,             // one-cycle event pulses per flag bit
  input  wire logic [7:0] orient_a_in,              // measured code, line 1 with line 2 grounded
  input  wire logic [7:0] orient_b_in,              // measured code, line 2 with line 1 grounded
  input  wire logic [3:0] overvolt_active_in,       // usb, ground sense, line 1, line 2
  input  wire logic [2:0] line1_path_state_in,      // line 1 switch path state
  input  wire logic [2:0] line2_path_state_in,      // line 2 switch path state
  output logic [4:0]      detect_mask_out,          // event mask bits
  output logic [7:0]      mic_thresh_lower_out,     // lower mic detection threshold
  output logic [7:0]      mic_thresh_upper_out,     // upper mic detection threshold
  output logic [1:0]      sense_current_out,        // detection current in effect
  output logic            gate_out_a_out,           // external gate driver a enable
  output logic            gate_out_b_out,           // external gate driver b enable
  output logic [1:0]      gate_out_current_out,     // gate drive current code
  output logic            overvolt_guard_on_out,    // over-voltage guard enable
  output logic            overcurrent_guard_on_out  // over-current guard enable
);

  import asd_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    asd_ser_type ser;
    logic [2:0]  bit_cnt;
    logic        byte_done;
    logic [7:0]  shift;
    logic [7:0]  ptr;
    logic        rw;
    logic        scl_prev;
    logic        sda_prev;
    logic        sda_drive;
    logic [4:0]  flags;
    logic [4:0]  mask;
    logic [7:0]  orient_a;
    logic [7:0]  orient_b;
    logic [7:0]  mic_lower;
    logic [7:0]  mic_upper;
    logic [1:0]  cur_select;
    logic [1:0]  cur_state;
    logic [2:0]  gate;
    logic [1:0]  prot_en;
    logic [5:0]  prot_state;
  } asd_state_type;

  asd_state_type state_reg;
  asd_state_type state_next;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic [7:0] rd_data;
  logic [7:0] rd_next;
  logic       wr_en;
  logic [4:0] flag_clear;

  // ****************************************************************
  // read mux
  // ****************************************************************
  // write-only and unmapped offsets read as zero
  function automatic logic [7:0] read_reg(input asd_state_type s, input logic [7:0] addr);
    logic [7:0] val;
    val = 8'h00;
    case (addr)
      OFF_EVENT_FLAGS:  val = {3'h0, s.flags};
      OFF_DETECT_MASK:  val = {3'h0, s.mask};
      OFF_ORIENT_A:     val = s.orient_a;
      OFF_ORIENT_B:     val = s.orient_b;
      OFF_MIC_LOWER:    val = s.mic_lower;
      OFF_MIC_UPPER:    val = s.mic_upper;
      OFF_CUR_STATE:    val = {6'h00, s.cur_state};
      OFF_GATE_CONTROL: val = {5'h00, s.gate};
      OFF_PROT_ENABLE:  val = {6'h00, s.prot_en};
      OFF_PROT_STATE:   val = {2'h0, s.prot_state};
      default:          val = 8'h00;
    endcase
    return val;
  endfunction : read_reg

  // bus line edges; pins are taken as synchronous to the clock
  assign scl_rise   = scl_in & ~state_reg.scl_prev;
  assign scl_fall   = ~scl_in & state_reg.scl_prev;
  assign start_seen = scl_in & state_reg.scl_prev & state_reg.sda_prev & ~sda_in;
  assign stop_seen  = scl_in & state_reg.scl_prev & ~state_reg.sda_prev & sda_in;
  assign rd_data    = read_reg(state_reg, state_reg.ptr);
  assign rd_next    = read_reg(state_reg, state_reg.ptr);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_next          = state_reg;
    wr_en               = 1'b0;
    flag_clear          = 5'h00;
    state_next.scl_prev = scl_in;
    state_next.sda_prev = sda_in;

    if (start_seen) begin
      // repeated start is legal from any state
      state_next.ser       = SER_ADDR;
      state_next.bit_cnt   = 3'h0;
      state_next.byte_done = 1'b0;
      state_next.sda_drive = 1'b0;
    end else if (stop_seen) begin
      state_next.ser       = SER_IDLE;
      state_next.sda_drive = 1'b0;
    end else begin
      case (state_reg.ser)
        SER_IDLE: begin
          state_next.sda_drive = 1'b0;
        end
        SER_ADDR, SER_REG, SER_WDATA: begin
          if (scl_rise) begin
            state_next.shift   = {state_reg.shift[6:0], sda_in};
            state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
            if (state_reg.bit_cnt == BIT_LAST) begin
              state_next.byte_done = 1'b1;
            end
          end else if (scl_fall && state_reg.byte_done) begin
            state_next.byte_done = 1'b0;
            state_next.bit_cnt   = 3'h0;
            state_next.sda_drive = 1'b1;
            if (state_reg.ser == SER_ADDR) begin
              // a foreign address is left alone until the next start
              if (state_reg.shift[7:1] == DEV_ADDR) begin
                state_next.rw  = state_reg.shift[0];
                state_next.ser = SER_ADDR_ACK;
              end else begin
                state_next.sda_drive = 1'b0;
                state_next.ser       = SER_IDLE;
              end
            end else if (state_reg.ser == SER_REG) begin
              state_next.ptr = state_reg.shift;
              state_next.ser = SER_REG_ACK;
            end else begin
              wr_en          = 1'b1;
              state_next.ptr = state_reg.ptr + 8'h01;
              state_next.ser = SER_WDATA_ACK;
            end
          end
        end
        SER_ADDR_ACK: begin
          if (scl_fall) begin
            if (state_reg.rw) begin
              // load the first byte; reading the flags clears them
              state_next.shift     = rd_data;
              state_next.sda_drive = ~rd_data[7];
              state_next.bit_cnt   = 3'h0;
              state_next.ser       = SER_RDATA;
              if (state_reg.ptr == OFF_EVENT_FLAGS) begin
                flag_clear = state_reg.flags;
              end
            end else begin
              state_next.sda_drive = 1'b0;
              state_next.ser       = SER_REG;
            end
          end
        end
        SER_REG_ACK, SER_WDATA_ACK: begin
          if (scl_fall) begin
            state_next.sda_drive = 1'b0;
            state_next.ser       = SER_WDATA;
          end
        end
        SER_RDATA: begin
          if (scl_rise) begin
            state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
            if (state_reg.bit_cnt == BIT_LAST) begin
              state_next.byte_done = 1'b1;
            end
          end else if (scl_fall) begin
            if (state_reg.byte_done) begin
              state_next.byte_done = 1'b0;
              state_next.sda_drive = 1'b0;
              state_next.ptr       = state_reg.ptr + 8'h01;
              state_next.ser       = SER_RDATA_ACK;
            end else begin
              state_next.shift     = {state_reg.shift[6:0], 1'b0};
              state_next.sda_drive = ~state_reg.shift[6];
            end
          end
        end
        SER_RDATA_ACK: begin
          if (scl_rise) begin
            // a not-acknowledge ends the read burst
            if (sda_in) begin
              state_next.ser = SER_IDLE;
            end else begin
              state_next.byte_done = 1'b1;
            end
          end else if (scl_fall && state_reg.byte_done) begin
            state_next.byte_done = 1'b0;
            state_next.shift     = rd_next;
            state_next.sda_drive = ~rd_next[7];
            state_next.bit_cnt   = 3'h0;
            state_next.ser       = SER_RDATA;
            if (state_reg.ptr == OFF_EVENT_FLAGS) begin
              flag_clear = state_reg.flags;
            end
          end
        end
        default: begin
          state_next.ser       = SER_IDLE;
          state_next.sda_drive = 1'b0;
        end
      endcase
    end

    // register writes; the write-only select takes effect here
    if (wr_en) begin
      case (state_reg.ptr)
        OFF_DETECT_MASK:  state_next.mask       = state_reg.shift[4:0];
        OFF_MIC_LOWER:    state_next.mic_lower  = state_reg.shift;
        OFF_MIC_UPPER:    state_next.mic_upper  = state_reg.shift;
        OFF_CUR_SELECT:   state_next.cur_select = state_reg.shift[1:0];
        OFF_GATE_CONTROL: state_next.gate       = state_reg.shift[2:0];
        OFF_PROT_ENABLE:  state_next.prot_en    = state_reg.shift[1:0];
        default: begin
        end
      endcase
    end

    // status follows the hardware every cycle
    state_next.orient_a   = orient_a_in;
    state_next.orient_b   = orient_b_in;
    state_next.cur_state  = state_reg.cur_select;
    state_next.prot_state = {overvolt_active_in & {4{state_reg.prot_en[BIT_OVP_EN]}},
                             state_reg.prot_en[BIT_OCP_EN] && (line1_path_state_in == PATH_TO_GROUND),
                             state_reg.prot_en[BIT_OCP_EN] && (line2_path_state_in == PATH_TO_GROUND)};

    // soft reset restores every host register; the bit itself never stores
    if (wr_en && (state_reg.ptr == OFF_SOFT_RESET) && state_reg.shift[BIT_SOFT_RESET]) begin
      state_next.mask       = RST_DETECT_MASK;
      state_next.mic_lower  = RST_MIC_LOWER;
      state_next.mic_upper  = RST_MIC_UPPER;
      state_next.cur_select = RST_CUR_SELECT;
      state_next.gate       = RST_GATE_CONTROL;
      state_next.prot_en    = RST_PROT_ENABLE;
      flag_clear            = state_reg.flags;
    end

    // an event arriving with a clear is kept: set wins
    state_next.flags = (state_reg.flags & ~flag_clear) | event_set_in;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg            <= '0;
      state_reg.ser        <= SER_IDLE;
      state_reg.scl_prev   <= 1'b1;
      state_reg.sda_prev   <= 1'b1;
      state_reg.flags      <= RST_EVENT_FLAGS;
      state_reg.mask       <= RST_DETECT_MASK;
      state_reg.orient_a   <= RST_ORIENT;
      state_reg.orient_b   <= RST_ORIENT;
      state_reg.mic_lower  <= RST_MIC_LOWER;
      state_reg.mic_upper  <= RST_MIC_UPPER;
      state_reg.cur_select <= RST_CUR_SELECT;
      state_reg.cur_state  <= RST_CUR_SELECT;
      state_reg.gate       <= RST_GATE_CONTROL;
      state_reg.prot_en    <= RST_PROT_ENABLE;
      state_reg.prot_state <= RST_PROT_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // both open-drain pins only ever pull low
  assign sda_out                  = 1'b0;
  assign sda_oe_n_out             = ~state_reg.sda_drive;
  assign int_n_out                = 1'b0;
  assign int_oe_n_out             = ~(|(state_reg.flags & ~state_reg.mask));
  assign detect_mask_out          = state_reg.mask;
  assign mic_thresh_lower_out     = state_reg.mic_lower;
  assign mic_thresh_upper_out     = state_reg.mic_upper;
  assign sense_current_out        = state_reg.cur_select;
  assign gate_out_a_out           = state_reg.gate[BIT_GATE_EN];
  assign gate_out_b_out           = state_reg.gate[BIT_GATE_EN];
  assign gate_out_current_out     = state_reg.gate[1:0];
  assign overvolt_guard_on_out    = state_reg.prot_en[BIT_OVP_EN];
  assign overcurrent_guard_on_out = state_reg.prot_en[BIT_OCP_EN];

endmodule : asd_regs

// [testbench/asd_regs_sva.sv]
// port assertions for the detection and protection register bank
`timescale 1ns/10ps

module asd_regs_sva
  import asd_pkg::*;
(
  input wire logic       clock_in,                // clock
  input wire logic       sys_rst_in,              // reset
  input wire logic       scl_in,                  // serial clock
  input wire logic       sda_out,                 // data drive value
  input wire logic       int_n_out,               // irq drive value
  input wire logic       int_oe_n_out,            // irq enable
  input wire logic [4:0] event_set_in,            // event pulses
  input wire logic [4:0] detect_mask_out,         // mask bits
  input wire logic [7:0] mic_thresh_lower_out,    // lower threshold
  input wire logic [7:0] mic_thresh_upper_out,    // upper threshold
  input wire logic [1:0] sense_current_out,       // current code
  input wire logic       gate_out_a_out,          // gate a
  input wire logic       gate_out_b_out,          // gate b
  input wire logic [1:0] gate_out_current_out,    // gate current
  input wire logic       overvolt_guard_on_out,   // ovp enable
  input wire logic       overcurrent_guard_on_out // ocp enable
);
  logic        hit; // an event the mask lets through
  logic [28:0] cfg; // all configuration outputs side by side
  assign hit = |(event_set_in & ~detect_mask_out);
  assign cfg = {detect_mask_out, mic_thresh_lower_out, mic_thresh_upper_out, sense_current_out, gate_out_a_out,
                gate_out_b_out, gate_out_current_out, overvolt_guard_on_out, overcurrent_guard_on_out};

  default clocking dc @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  // defaults are seen just after release, so reset must not disable this one
  a_reset_defaults: assert property (disable iff (1'b0) $fell(sys_rst_in) |->
    cfg == {5'h08, 8'h20, 8'hFF, 2'h2, 1'b0, 1'b0, 2'h0, 1'b1, 1'b1} && int_oe_n_out)
    else $error("outputs not at defaults after reset");
  a_gate_pair: assert property (gate_out_a_out == gate_out_b_out)
    else $error("gate outputs differ");
  a_pins_drive_low: assert property (!sda_out && !int_n_out)
    else $error("open-drain drive value not low");
  a_event_raises: assert property (hit |=> !int_oe_n_out)
    else $error("unmasked event did not pull interrupt");
  a_masked_quiet: assert property (int_oe_n_out && !hit ##1 $stable(detect_mask_out) |-> int_oe_n_out)
    else $error("masked event pulled interrupt");
  a_int_fall_cause: assert property ($fell(int_oe_n_out) |-> $past(hit) || $changed(detect_mask_out))
    else $error("interrupt asserted without cause");
  a_int_rise_cause: assert property ($rose(int_oe_n_out) |-> !scl_in || $changed(detect_mask_out))
    else $error("interrupt released outside a read");
  // writes land only after a serial clock fall, never mid high phase
  a_cfg_on_low: assert property ($changed(cfg) |-> !scl_in)
    else $error("configuration changed while serial clock high");

  c_int_low: cover property ($fell(int_oe_n_out));
  c_gate_on: cover property ($rose(gate_out_a_out));
  c_masked: cover property (int_oe_n_out && |event_set_in && !hit);
endmodule : asd_regs_sva

bind asd_regs asd_regs_sva u_sva (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .scl_in(scl_in), .sda_out(sda_out), .int_n_out(int_n_out),
  .int_oe_n_out(int_oe_n_out), .event_set_in(event_set_in), .detect_mask_out(detect_mask_out),
  .mic_thresh_lower_out(mic_thresh_lower_out), .mic_thresh_upper_out(mic_thresh_upper_out),
  .sense_current_out(sense_current_out), .gate_out_a_out(gate_out_a_out), .gate_out_b_out(gate_out_b_out),
  .gate_out_current_out(gate_out_current_out), .overvolt_guard_on_out(overvolt_guard_on_out),
  .overcurrent_guard_on_out(overcurrent_guard_on_out)
);

// [testbench/asd_host_model.sv]
// two-wire host reaching the register bank over its serial pins
`timescale 1ns/10ps

module asd_host_model
  import asd_pkg::*;
(
  input  wire logic clock_in,    // bench clock
  input  wire logic sda_line_in, // resolved data line
  output logic      scl_out,     // serial clock
  output logic      sda_out      // low pulls data line
);
  int half = 4; // cycles per half period; raised for a slow host

  // both lines idle high before the first frame, so the slave sees no false edge after reset
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // one half period with both lines held; data moves while the clock is high only in start and stop
  task automatic drive(input logic c, input logic d);
    scl_out <= c;
    sda_out <= d;
    repeat (half) @(posedge clock_in);
  endtask : drive

  task automatic put_bit(input logic b);
    drive(1'b0, b);
    drive(1'b1, b);
    drive(1'b0, b);
  endtask : put_bit

  // line released, sampled at the end of the high phase
  task automatic get_bit(output logic b);
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    b = sda_line_in;
    drive(1'b0, 1'b1);
  endtask : get_bit

  // a byte then the acknowledge slot; high means refused
  task automatic put_byte(input logic [7:0] d, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(nak);
  endtask : put_byte

  task automatic start();
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    drive(1'b1, 1'b0);
    drive(1'b0, 1'b0);
  endtask : start

  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic nak);
    logic [2:0] n;
    start();
    put_byte({dev, 1'b0}, n[0]);
    put_byte(ptr, n[1]);
    put_byte(d, n[2]);
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
    nak = |n;
  endtask : wr_reg

  // pointer write, repeated start, one byte closed with a refusal
  task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] d);
    logic n;
    start();
    put_byte({DEV_ADDR, 1'b0}, n);
    put_byte(ptr, n);
    start();
    put_byte({DEV_ADDR, 1'b1}, n);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(1'b1);
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
  endtask : rd_reg

  // two bytes in one burst; the host acknowledges the first so the slave goes on
  task automatic rd_two(input logic [7:0] ptr, output logic [15:0] d);
    logic n;
    start();
    put_byte({DEV_ADDR, 1'b0}, n);
    put_byte(ptr, n);
    start();
    put_byte({DEV_ADDR, 1'b1}, n);
    for (int i = 15; i >= 0; i--) begin
      get_bit(d[i]);
      if (i == 8) begin
        put_bit(1'b0);
      end
    end
    put_bit(1'b1);
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
  endtask : rd_two
endmodule : asd_host_model

// [testbench/asd_regs_tb_top.sv]
// self-checking bench for the detection and protection register bank
`timescale 1ns/10ps

module asd_regs_tb_top;
  import asd_pkg::*;

  logic             clock_in, scl, host_sda, sda_o, sda_oe_n, int_o, int_oe_n, nak;
  logic             gate_a, gate_b, ovp_on, ocp_on;
  logic             sys_rst_in = 1'b1;
  logic [1:0]       cur, gate_cur;
  logic [2:0]       path1 = 3'h0, path2 = 3'h0;
  logic [3:0]       ovp_act = 4'h8;
  logic [4:0]       event_set = 5'h00, mask;
  logic [7:0]       orient_a = 8'h00, orient_b = 8'h00, mic_lo, mic_hi, rd;
  int               errors = 0, check_count = 0;
  // open-drain lines: a released line reads the pull-up level
  wire logic        sda_line = host_sda & (sda_oe_n | sda_o);
  wire logic        int_line = int_oe_n | int_o;
  wire logic [31:0] outs = {mic_hi, mic_lo, 3'h0, mask, cur, gate_cur, gate_a, gate_b, ovp_on, ocp_on};

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  asd_host_model host (.clock_in(clock_in), .sda_line_in(sda_line), .scl_out(scl), .sda_out(host_sda));

  asd_regs uut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o),
    .sda_oe_n_out(sda_oe_n), .int_n_out(int_o), .int_oe_n_out(int_oe_n), .event_set_in(event_set),
    .orient_a_in(orient_a), .orient_b_in(orient_b), .overvolt_active_in(ovp_act),
    .line1_path_state_in(path1), .line2_path_state_in(path2), .detect_mask_out(mask),
    .mic_thresh_lower_out(mic_lo), .mic_thresh_upper_out(mic_hi), .sense_current_out(cur),
    .gate_out_a_out(gate_a), .gate_out_b_out(gate_b), .gate_out_current_out(gate_cur),
    .overvolt_guard_on_out(ovp_on), .overcurrent_guard_on_out(ocp_on)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    host.wr_reg(DEV_ADDR, ptr, d, nak);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] ptr, input logic [7:0] exp);
    host.rd_reg(ptr, rd);
    check(what, 32'(rd), 32'(exp));
  endtask : rdc

  task automatic pulse(input logic [4:0] bits);
    @(posedge clock_in);
    event_set <= bits;
    @(posedge clock_in);
    event_set <= 5'h00;
    repeat (3) @(posedge clock_in);
  endtask : pulse

  task automatic t_reset();
    logic [7:0] exp [12];
    exp = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h20, 8'hFF, 8'h00, 8'h00, 8'h02, 8'h00, 8'h03, 8'h20};
    for (int i = 0; i < 12; i++) begin
      rdc("reset value", OFF_EVENT_FLAGS + 8'(i), exp[i]);
    end
  endtask : t_reset

  // every current and gate code, gate enable toggling with the low bit
  task automatic t_codes();
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CUR_SELECT, 8'(i));
      wr(OFF_GATE_CONTROL, 8'(i) | (i[0] ? 8'h04 : 8'h00));
      check("current out", 32'(cur), 32'(i));
      rdc("current state", OFF_CUR_STATE, 8'(i));
      check("gate drive", {28'h0, gate_a, gate_b, gate_cur}, 32'(i) | (i[0] ? 32'hC : 32'h0));
    end
  endtask : t_codes

  task automatic t_rw();
    logic [15:0] pair;
    wr(OFF_MIC_LOWER, 8'hA5);
    wr(OFF_MIC_UPPER, 8'h5A);
    wr(OFF_PROT_ENABLE, 8'h02);
    wr(OFF_ORIENT_A, 8'hFF);
    orient_a <= 8'h81;
    orient_b <= 8'h3C;
    check("outputs", outs, 32'h5AA5_08FE);
    rdc("lower threshold", OFF_MIC_LOWER, 8'hA5);
    // burst read walks the pointer on after each byte, before the host acknowledges
    host.rd_two(OFF_MIC_LOWER, pair);
    check("burst read", 32'(pair), 32'hA55A);
    // the host divides this code by the current in effect to get resistance
    rdc("orientation a", OFF_ORIENT_A, 8'h81);
    rdc("orientation b", OFF_ORIENT_B, 8'h3C);
  endtask : t_rw

  task automatic t_prot();
    wr(OFF_PROT_ENABLE, 8'h03);
    ovp_act <= 4'b0101;
    path1 <= 3'h2;
    path2 <= 3'h3;
    rdc("protection a", OFF_PROT_STATE, 8'h16);
    ovp_act <= 4'b1010;
    path1 <= 3'h3;
    path2 <= 3'h2;
    rdc("protection b", OFF_PROT_STATE, 8'h29);
    wr(OFF_PROT_ENABLE, 8'h00);
    rdc("protection off", OFF_PROT_STATE, 8'h00);
  endtask : t_prot

  // each mask bit hides only its own flag; a neighbour still pulls the pin
  task automatic t_irq();
    logic [4:0] own, other;
    for (int i = 0; i < 5; i++) begin
      own = 5'h01 << i;
      other = 5'h01 << ((i + 1) % 5);
      wr(OFF_DETECT_MASK, {3'h0, own});
      check("mask out", 32'(mask), 32'(own));
      pulse(own);
      check("masked pin", 32'(int_line), 32'h1);
      pulse(other);
      check("unmasked pin", 32'(int_line), 32'h0);
      rdc("event flags", OFF_EVENT_FLAGS, {3'h0, own | other});
      check("released pin", 32'(int_line), 32'h1);
    end
  endtask : t_irq

  task automatic t_soft();
    wr(OFF_SOFT_RESET, 8'h01);
    check("defaults", outs, 32'hFF20_0883);
    rdc("soft reset bit", OFF_SOFT_RESET, 8'h00);
  endtask : t_soft

  // slow host: a foreign address is refused and changes nothing
  task automatic t_slow();
    host.half = 8;
    host.wr_reg(DEV_ADDR ^ 7'h01, OFF_MIC_LOWER, 8'h77, nak);
    check("foreign address", 32'(nak), 32'h1);
    wr(OFF_MIC_UPPER, 8'h33);
    check("write ack", 32'(nak), 32'h0);
    rdc("lower kept", OFF_MIC_LOWER, 8'h20);
    rdc("upper slow", OFF_MIC_UPPER, 8'h33);
    host.half = 4;
  endtask : t_slow

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (5) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    t_reset();
    t_codes();
    t_rw();
    t_prot();
    t_irq();
    t_soft();
    t_slow();
    test_done();
  end

  // about fifty transfers of a few hundred cycles; the cap leaves ample margin
  initial begin
    repeat (80000) @(posedge clock_in);
    errors++;
    test_done();
  end
endmodule : asd_regs_tb_top
